// >>> src/fpc_defs.vh
// constants for the floating-point condition, test and nan logic
//
// Overview of operation
// - condition codes update from the result alone after arithmetic or register moves.
// - thirty-two conditional tests selected by a six-bit predicate field.
// - unordered compare sets the nan condition code bit.
// - any nan arithmetic result sets the nan condition code bit.
// - nan bit equal to one means unordered in every test.
// - plain equal and not-equal tests never raise the branch-unordered flag; signaling ones raise it when nan bit is set.
// - unaware tests raise branch-unordered flag when nan bit is set.
// - branch-unordered flag rising with its enable set causes a trap.
// - unaware greater, not-greater, greater-equal, not-greater-equal equations.
// - unaware less, not-less, less-equal, not-less-equal equations.
// - unaware greater-or-less, its complement, ordered and unordered equations.
// - aware tests never raise the branch-unordered flag.
// - aware ordered-greater and greater-equal tests with their complements.
// - aware ordered-less and less-equal tests with their complements.
// - aware greater-or-less, unordered-equal, ordered, unordered tests.
// - false, true, signaling false, signaling true, signaling equal, not-equal.
// - plain true and false leave flag alone; signaling ones raise it.
// - opposite-sign zeros sum to plus zero, minus zero when rounding minus.
// - one quiet nan is returned; two quiet nans return destination.
// - any signaling nan operand sets the signaling-nan flag.
// - signaling-nan trap enabled traps; a trapped add leaves destination unmodified, a move still writes it.
// - trap disabled, an add quiets the signaling operand then selects as quiet; a move copies it unquieted.
// - condition byte holds sign, zero, infinity and nan bits.
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// ---------------------------------------------------------------------
// apb register offsets
// ---------------------------------------------------------------------
`define FPC_STATUS_OFS   12'h000
`define FPC_CONTROL_OFS  12'h004
`define FPC_PRED_OFS     12'h008
`define FPC_SRCHI_OFS    12'h00c
`define FPC_SRCLO_OFS    12'h010
`define FPC_DSTHI_OFS    12'h014
`define FPC_DSTLO_OFS    12'h018
`define FPC_RESHI_OFS    12'h01c
`define FPC_RESLO_OFS    12'h020
`define FPC_CMD_OFS      12'h024

// ---------------------------------------------------------------------
// status register fields: condition byte [27:24], exception byte [15:8]
// ---------------------------------------------------------------------
`define FPC_CC_N         27
`define FPC_CC_Z         26
`define FPC_CC_I         25
`define FPC_CC_NAN       24
`define FPC_EXC_BRANCH_UNORDERED_FLAG     15
`define FPC_EXC_SIGNALING_NAN_FLAG     14
`define FPC_EXC_OPERAND_ERROR_FLAG    13
`define FPC_TRUE_BIT     0

// control register: enable byte [15:8], rounding mode [5:4]
`define FPC_EN_BRANCH_UNORDERED_FLAG      15
`define FPC_EN_SIGNALING_NAN_FLAG      14
`define FPC_RND_LO       4
`define FPC_RND_NEAREST  2'h0
`define FPC_RND_ZERO     2'h1
`define FPC_RND_MINUS    2'h2
`define FPC_RND_PLUS     2'h3

// command codes written to the command register
`define FPC_CMD_ADD      2'h1
`define FPC_CMD_MOVE     2'h2
`define FPC_CMD_CMP      2'h3

// reset values
`define FPC_STATUS_RST   32'h0000_0000
`define FPC_CONTROL_RST  32'h0000_0000

`endif

// >>> src/fpc_top.v
// floating-point condition, predicate test and special operand logic
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fpc_defs.vh"

module fpc_top #(
  parameter EXP_W = 15,
  parameter MAN_W = 64
) (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         trap_reg,
  output wire        test_true
);

  localparam W = 1 + EXP_W + MAN_W;

  // ---------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------
  reg rst_sync1_reg;
  reg rst_n_reg;

  // two-flop release so deassertion is clean
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  reg  [31:0]  status_reg;
  reg  [31:0]  control_reg;
  reg  [5:0]   pred_reg;
  reg  [W-1:0] src_reg;
  reg  [W-1:0] dst_reg;
  reg  [W-1:0] res_reg;

  wire         wr_en = psel & penable & pwrite;
  wire         cmd_wr = wr_en & (paddr == `FPC_CMD_OFS);
  wire [1:0]   cmd = pwdata[1:0];
  wire         pred_wr = wr_en & (paddr == `FPC_PRED_OFS);
  wire         ctl_wr  = wr_en & (paddr == `FPC_CONTROL_OFS);
  wire         stat_wr = wr_en & (paddr == `FPC_STATUS_OFS);
  wire         shi_wr  = wr_en & (paddr == `FPC_SRCHI_OFS);
  wire         slo_wr  = wr_en & (paddr == `FPC_SRCLO_OFS);
  wire         dhi_wr  = wr_en & (paddr == `FPC_DSTHI_OFS);
  wire         dlo_wr  = wr_en & (paddr == `FPC_DSTLO_OFS);

  // ---------------------------------------------------------------------
  // operand word mapping
  // ---------------------------------------------------------------------
  // an extended operand is wider than two bus words, so the high word is
  // packed: sign and exponent sit in its low half, the top sixteen
  // mantissa bits in its upper half, and the low word is bits 31:0.
  // mantissa bits 47:32 have no window and stay zero; software that
  // needs full precision cannot reach them through this bus.
  // the explicit integer bit rides in the upper half of the high word,
  // and the quiet bit just below it.
  localparam HW = 16;

  // packed high words, read back the same way they were written
  wire [31:0]  src_hi_word = {src_reg[MAN_W-1:MAN_W-HW], src_reg[W-1:MAN_W]};
  wire [31:0]  dst_hi_word = {dst_reg[MAN_W-1:MAN_W-HW], dst_reg[W-1:MAN_W]};
  wire [31:0]  res_hi_word = {res_reg[MAN_W-1:MAN_W-HW], res_reg[W-1:MAN_W]};

  // single-cycle access phase, no wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ---------------------------------------------------------------------
  // operand classification
  // ---------------------------------------------------------------------
  wire         s_sgn  = src_reg[W-1];
  wire         d_sgn  = dst_reg[W-1];
  wire         s_emax = &src_reg[W-2:MAN_W];
  wire         d_emax = &dst_reg[W-2:MAN_W];
  wire         s_frac = |src_reg[MAN_W-2:0];
  wire         d_frac = |dst_reg[MAN_W-2:0];
  wire         s_nan  = s_emax & s_frac;
  wire         d_nan  = d_emax & d_frac;
  // quiet bit is the top fraction bit; clear means signaling
  wire         s_signaling_nan_flag = s_nan & ~src_reg[MAN_W-2];
  wire         d_signaling_nan_flag = d_nan & ~dst_reg[MAN_W-2];
  wire         s_inf  = s_emax & ~s_frac;
  wire         d_inf  = d_emax & ~d_frac;
  wire         s_zero = ~|src_reg[W-2:0];
  wire         d_zero = ~|dst_reg[W-2:0];
  wire [1:0]   rnd    = control_reg[`FPC_RND_LO+1:`FPC_RND_LO];

  // quieted copies of operands
  wire [W-1:0] src_q = src_reg | ({{(W-1){1'b0}}, 1'b1} << (MAN_W-2));
  wire [W-1:0] dst_q = dst_reg | ({{(W-1){1'b0}}, 1'b1} << (MAN_W-2));
  wire [W-1:0] qnan_def = {1'b0, {EXP_W{1'b1}}, 2'b11, {(MAN_W-2){1'b0}}};
  wire [W-1:0] inf_pos  = {1'b0, {EXP_W{1'b1}}, {MAN_W{1'b0}}};

  // ---------------------------------------------------------------------
  // addition special-case result selection
  // ---------------------------------------------------------------------
  reg  [W-1:0] add_res;
  reg          add_operand_error_flag;
  reg          add_hold;

  always @* begin
    add_res   = dst_reg;
    add_operand_error_flag = 1'b0;
    add_hold  = 1'b0;
    if (s_nan | d_nan) begin
      if ((s_signaling_nan_flag | d_signaling_nan_flag) & control_reg[`FPC_EN_SIGNALING_NAN_FLAG]) begin
        add_hold = 1'b1;
        add_res  = dst_reg;
      end else if (d_nan) begin
        add_res = dst_q;
      end else begin
        add_res = src_q;
      end
    end else if (s_inf & d_inf & (s_sgn != d_sgn)) begin
      add_res   = qnan_def;
      add_operand_error_flag = 1'b1;
    end else if (s_inf | d_inf) begin
      add_res = s_inf ? src_reg : dst_reg;
    end else if (s_zero & d_zero) begin
      if (s_sgn == d_sgn)
        add_res = {s_sgn, {(W-1){1'b0}}};
      else
        add_res = {(rnd == `FPC_RND_MINUS), {(W-1){1'b0}}};
    end else if (s_zero) begin
      add_res = dst_reg;
    end else if (d_zero) begin
      add_res = src_reg;
    end else begin
      // finite sums belong to the arithmetic core, not modelled here
      add_res = dst_reg;
    end
  end

  // ---------------------------------------------------------------------
  // condition codes from a result value
  // ---------------------------------------------------------------------
  function [3:0] cc_of;
    input [W-1:0] v;
    reg           e_max;
    reg           f_nz;
    begin
      e_max = &v[W-2:MAN_W];
      f_nz  = |v[MAN_W-2:0];
      cc_of = {v[W-1], ~|v[W-2:0], e_max & ~f_nz, e_max & f_nz};
    end
  endfunction

  reg  [W-1:0] op_res;
  reg  [3:0]   op_cc;
  reg          op_signaling_nan_flag;

  always @* begin
    op_res  = res_reg;
    op_cc   = status_reg[`FPC_CC_N:`FPC_CC_NAN];
    op_signaling_nan_flag = 1'b0;
    case (cmd)
      `FPC_CMD_ADD: begin
        op_res  = add_res;
        op_cc   = cc_of(add_res);
        op_signaling_nan_flag = s_signaling_nan_flag | d_signaling_nan_flag;
      end
      `FPC_CMD_MOVE: begin
        op_res  = src_reg;
        op_cc   = cc_of(src_reg);
        op_signaling_nan_flag = s_signaling_nan_flag;
      end
      `FPC_CMD_CMP: begin
        op_cc   = {1'b0, 1'b0, 1'b0, s_nan | d_nan};
        if (!(s_nan | d_nan)) begin
          op_cc[3] = (s_zero & d_zero) ? 1'b0 :
                     (d_sgn & ~s_sgn) | (d_sgn == s_sgn & (d_sgn ^ (dst_reg < src_reg)));
          op_cc[2] = (dst_reg == src_reg) | (s_zero & d_zero);
        end
        op_signaling_nan_flag = s_signaling_nan_flag | d_signaling_nan_flag;
      end
      default: begin
        op_cc = status_reg[`FPC_CC_N:`FPC_CC_NAN];
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // predicate decoder
  // ---------------------------------------------------------------------
  wire cn   = status_reg[`FPC_CC_N];
  wire cz   = status_reg[`FPC_CC_Z];
  wire cnan = status_reg[`FPC_CC_NAN];
  reg  t_val;
  reg  t_sig;

  always @* begin
    case (pred_reg[3:0])
      4'h0: t_val = 1'b0;
      4'h1: t_val = cz;
      4'h2: t_val = ~(cnan | cz | cn);
      4'h3: t_val = cz | ~(cnan | cn);
      4'h4: t_val = cn & ~(cnan | cz);
      4'h5: t_val = cz | (cn & ~cnan);
      4'h6: t_val = ~(cnan | cz);
      4'h7: t_val = ~cnan;
      4'h8: t_val = cnan;
      4'h9: t_val = cnan | cz;
      4'ha: t_val = cnan | ~(cn | cz);
      4'hb: t_val = cnan | cz | ~cn;
      4'hc: t_val = cnan | (cn & ~cz);
      4'hd: t_val = cnan | cz | cn;
      4'he: t_val = ~cz;
      default: t_val = 1'b1;
    endcase
    t_sig = pred_reg[4] & (pred_reg[3:0] != 4'h1) & (pred_reg[3:0] != 4'he);
    if (pred_reg[4] & ((pred_reg[3:0] == 4'h1) | (pred_reg[3:0] == 4'he)))
      t_sig = 1'b1;
  end

  // signaling-equal pair sits at 010001/011110; plain pair at 000001/001110
  assign test_true = pred_reg[5] ? 1'b0 : t_val;
  // re-evaluated every cycle the predicate is held, so the flag is
  // re-set even after software clears it; a user who wants it to stay
  // clear must first park the predicate on a non-signaling code
  wire pred_branch_unordered_flag = ~pred_reg[5] & t_sig & cnan;

  // ---------------------------------------------------------------------
  // register updates
  // ---------------------------------------------------------------------
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      status_reg  <= `FPC_STATUS_RST;
      control_reg <= `FPC_CONTROL_RST;
      pred_reg    <= 6'h00;
      src_reg     <= {W{1'b0}};
      dst_reg     <= {W{1'b0}};
      res_reg     <= {W{1'b0}};
      trap_reg    <= 1'b0;
    end else begin
      trap_reg <= 1'b0;
      if (ctl_wr)
        control_reg <= pwdata;
      if (pred_wr)
        pred_reg <= pwdata[5:0];
      // high word splits between exponent field and top of mantissa
      if (shi_wr) begin
        src_reg[W-1:MAN_W]        <= pwdata[HW-1:0];
        src_reg[MAN_W-1:MAN_W-HW] <= pwdata[31:HW];
      end
      if (slo_wr)
        src_reg[31:0] <= pwdata;
      // destination packs the same way as the source
      if (dhi_wr) begin
        dst_reg[W-1:MAN_W]        <= pwdata[HW-1:0];
        dst_reg[MAN_W-1:MAN_W-HW] <= pwdata[31:HW];
      end
      if (dlo_wr)
        dst_reg[31:0] <= pwdata;
      // software clears sticky bits by writing ones; new events win
      if (stat_wr)
        status_reg[15:8] <= status_reg[15:8] & ~pwdata[15:8];
      if (cmd_wr & (cmd != 2'h0)) begin
        if (!(cmd == `FPC_CMD_ADD & add_hold)) begin
          status_reg[`FPC_CC_N:`FPC_CC_NAN] <= op_cc;
          if (cmd != `FPC_CMD_CMP)
            res_reg <= op_res;
        end
        if (op_signaling_nan_flag)
          status_reg[`FPC_EXC_SIGNALING_NAN_FLAG] <= 1'b1;
        if (cmd == `FPC_CMD_ADD & add_operand_error_flag)
          status_reg[`FPC_EXC_OPERAND_ERROR_FLAG] <= 1'b1;
        if (op_signaling_nan_flag & control_reg[`FPC_EN_SIGNALING_NAN_FLAG])
          trap_reg <= 1'b1;
      end
      if (pred_branch_unordered_flag) begin
        status_reg[`FPC_EXC_BRANCH_UNORDERED_FLAG] <= 1'b1;
        // enabled unordered trap
        // only as the flag rises: a held test would otherwise keep the
        // trap line high for as long as the predicate stays in place
        if (control_reg[`FPC_EN_BRANCH_UNORDERED_FLAG] & ~status_reg[`FPC_EXC_BRANCH_UNORDERED_FLAG])
          trap_reg <= 1'b1;
      end
      // mirror lags the live test output by one cycle
      status_reg[`FPC_TRUE_BIT] <= test_true;
    end
  end

  // ---------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------
  // unmapped offsets fall through to zero; no error is signalled
  // because the bus never needs to stall or refuse this block
  always @* begin
    prdata = 32'h0000_0000;
    if (paddr == `FPC_STATUS_OFS)
      prdata = status_reg;
    else if (paddr == `FPC_CONTROL_OFS)
      prdata = control_reg;
    else if (paddr == `FPC_PRED_OFS)
      prdata = {26'h000_0000, pred_reg};
    else if (paddr == `FPC_SRCHI_OFS)
      prdata = src_hi_word;
    else if (paddr == `FPC_SRCLO_OFS)
      prdata = src_reg[31:0];
    else if (paddr == `FPC_DSTHI_OFS)
      prdata = dst_hi_word;
    else if (paddr == `FPC_DSTLO_OFS)
      prdata = dst_reg[31:0];
    else if (paddr == `FPC_RESHI_OFS)
      prdata = res_hi_word;
    else if (paddr == `FPC_RESLO_OFS)
      prdata = res_reg[31:0];
  end

endmodule // fpc_top
`default_nettype wire

// >>> tb/fpc_chk_asserts.sv
// port checker for fpc_top
`timescale 1ns/10ps
`default_nettype none
module fpc_chk (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trap_reg,
  input wire logic        test_true
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // completed write, predicate write and status read
  wire logic wr = psel && penable && pwrite;
  wire logic wp = wr && paddr == 12'h008;
  wire logic rs = psel && penable && !pwrite && paddr == 12'h000;
  logic      en_reg;
  // trap enables as last written; the trap flop may lag them a cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) en_reg <= 1'b0;
    else if (wr && paddr == 12'h004) en_reg <= |pwdata[15:14];
  end
  property p_rdy; psel && penable |-> pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("access stalled");
  property p_f; wp && pwdata[5:0] == 6'h00 |=> !test_true; endproperty
  a_f: assert property (p_f) else $error("false test true");
  property p_t; wp && pwdata[5:0] == 6'h0f |=> test_true; endproperty
  a_t: assert property (p_t) else $error("true test false");
  property p_sf; wp && pwdata[5:0] == 6'h10 |=> !test_true; endproperty
  a_sf: assert property (p_sf) else $error("signaling false true");
  property p_st; wp && pwdata[5:0] == 6'h1f |=> test_true; endproperty
  a_st: assert property (p_st) else $error("signaling true false");
  property p_mir; rs |-> prdata[0] == test_true; endproperty
  a_mir: assert property (p_mir) else $error("status mirror differs");
  property p_hold; !wr |=> $stable(test_true); endproperty
  a_hold: assert property (p_hold) else $error("test moved unprompted");
  property p_pulse; trap_reg |=> !trap_reg; endproperty
  a_pulse: assert property (p_pulse) else $error("trap longer than a cycle");
  property p_en; trap_reg |-> en_reg || $past(en_reg); endproperty
  a_en: assert property (p_en) else $error("trap while disabled");
endmodule // fpc_chk
bind fpc_top fpc_chk chk_u (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .trap_reg, .test_true);
`default_nettype wire

// >>> tb/fpc_seq.sv
// apb master standing in for the instruction sequencer
`timescale 1ns/10ps
`default_nettype none
module fpc_seq (
  input  wire logic        clock,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // one transfer; held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines flip so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock);
  endtask
endmodule // fpc_seq
`default_nettype wire

// >>> tb/fp_condition_test_and_nan_logic_tb_top.sv
// self-checking bench for fpc_top
`timescale 1ns/10ps
`default_nettype none
module fp_condition_test_and_nan_logic_tb_top;
  logic        clock;
  logic        arst_n = 1'b0;
  wire  logic  psel, penable, pwrite, pready, pslverr, trap_reg, test_true;
  wire  logic [11:0] paddr;
  wire  logic [31:0] pwdata, prdata;
  logic [31:0] q, t0, lfsr = 32'hc12a_e992;
  int          errors = 0, total_checks = 0, traps = 0, i, k;
  // operand classes: +norm, -norm, +0, -0, -inf, qnan and their codes
  logic [31:0] hv [6] = '{32'hffff_3fff, 32'hffff_bfff, 32'h0000_0000,
                          32'h0000_8000, 32'h0000_ffff, 32'hffff_7fff};
  logic [3:0]  cv [6] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'ha, 4'h1};
  fpc_top dut_u (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
                 .prdata, .pready, .pslverr, .trap_reg, .test_true);
  fpc_seq seq_u (.clock, .prdata, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  // clock and trap counter
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) traps <= traps + trap_reg;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected test result; upper half of each group is the complement
  function automatic logic pexp(input logic [5:0] c, input logic [3:0] f);
    logic n, z, u;
    {n, z, u} = {f[3], f[2], f[0]};
    if (c[5]) return 1'b0;
    case (c[3:0])
      4'h0: return 1'b0;
      4'h1: return z;
      4'h2: return !(u || z || n);
      4'h3: return z || !(u || n);
      4'h4: return n && !(u || z);
      4'h5: return z || (n && !u);
      4'h6: return !(u || z);
      4'h7: return !u;
      default: return !pexp(c ^ 6'h0f, f);
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    seq_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a);
    seq_u.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic op(input logic [1:0] c, input logic [31:0] sh, sl, dh, dl);
    wr(12'h00c, sh);
    wr(12'h010, sl);
    wr(12'h014, dh);
    wr(12'h018, dl);
    wr(12'h024, {30'h0, c});
  endtask
  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(12'h000);
    chk(q, 32'h0000_0000);
    wr(12'hffc, 32'hffff_ffff);
    rd(12'hffc);
    chk(q, 32'h0000_0000);
    // random result classes against predicate codes 0 through 32
    repeat (12) begin
      lfsr = nxt(lfsr);
      i = lfsr % 6;
      op(2'h2, hv[i], (i < 2 || i == 5) ? 32'hffff_ffff : 32'h0, 32'h0, 32'h0);
      rd(12'h000);
      chk(q[27:24], cv[i]);
      for (k = 0; k < 33; k++) begin
        wr(12'h008, 32'h0);
        wr(12'h000, {4'h0, cv[i], 24'h00_e000});
        wr(12'h008, k);
        rd(12'h000);
        chk(q[0], pexp(k[5:0], cv[i]));
        chk(test_true, pexp(k[5:0], cv[i]));
        chk(q[15], cv[i][0] & k[4]);
      end
    end
    chk(traps, 0);
    // held signaling test on a nan with the trap enabled
    op(2'h2, hv[5], 32'hffff_ffff, 32'h0, 32'h0);
    t0 = traps;
    wr(12'h004, 32'h0000_8000);
    wr(12'h008, 32'h12);
    repeat (4) @(posedge clock);
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h0);
    chk(traps - t0, 32'h0000_0001);
    // opposite zeros in each rounding mode
    for (k = 0; k < 4; k++) begin
      wr(12'h004, k << 4);
      op(2'h1, 32'h0, 32'h0, 32'h8000, 32'h0);
      rd(12'h01c);
      chk(q[15], k == 2);
    end
    wr(12'h004, 32'h0);
    op(2'h1, 32'hffff, 32'h0, 32'h7fff, 32'h0);
    rd(12'h000);
    chk({q[24], q[13]}, 2'b11);
    op(2'h1, 32'hffff, 32'h0, hv[0], 32'hffff_ffff);
    rd(12'h01c);
    chk(q, 32'h0000_ffff);
    op(2'h1, hv[5], 32'h1234_5678, hv[0], 32'hffff_ffff);
    rd(12'h020);
    chk(q, 32'h1234_5678);
    op(2'h1, hv[5], 32'h1234_5678, hv[5], 32'h0000_00ff);
    rd(12'h020);
    chk(q, 32'h0000_00ff);
    op(2'h1, 32'hbfff_7fff, 32'h1, hv[0], 32'hffff_ffff);
    rd(12'h000);
    chk(q[14], 1'b1);
    rd(12'h01c);
    chk(q, 32'hffff_7fff);
    // trapped signaling add leaves the previous result alone
    op(2'h1, 32'h0, 32'h0, 32'h0, 32'h0);
    wr(12'h004, 32'h0000_4000);
    t0 = traps;
    op(2'h1, 32'hbfff_7fff, 32'h1, hv[0], 32'hffff_ffff);
    repeat (2) @(posedge clock);
    rd(12'h01c);
    chk(q, 32'h0);
    chk(traps > t0, 1'b1);
    summarize();
  end
endmodule // fp_condition_test_and_nan_logic_tb_top
`default_nettype wire
